// ### src/sampling_ctl_regs.svh
// Purpose: register offsets, field positions and reset values
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: included by the sampling controller only
`ifndef SAMPLING_CTL_REGS_SVH
`define SAMPLING_CTL_REGS_SVH
`define OFS_SEN_LO 8'h00
`define OFS_SEN_HI 8'h04
`define OFS_STATUS 8'h08
`define OFS_REC_LIMIT 8'h0C
`define OFS_REC_COUNT 8'h10
`define OFS_EVSEL_BASE 8'h20
`define OFS_COUNT_BASE 8'h30
`define OFS_RELOAD_BASE 8'h40
`define SEN_STORE_BIT 31
`define STATUS_BUF_FULL_BIT 8
`define EVSEL_EDGE_BIT 18
`define EVSEL_ANY_BIT 21
`define EVSEL_EN_BIT 22
`define EVSEL_INV_BIT 23
`define RST_WORD 32'h0000_0000
`define EV_INSTR 8'hC0
`define EV_UOPS 8'hC2
`define EV_BRANCH 8'hC4
`define EV_MISPRED 8'hC5
`define EV_MEMOP 8'hD0
`define EV_LOADSRC 8'hD1
`define EV_LLHIT 8'hD2
`define EV_LOADLAT 8'hCD
`define UM_LOADLAT 8'h01
`define SKID_PLAIN 2'd1
`define SKID_FUSED 2'd2
`endif

// ### src/sampling_ctl_pkg.sv
// Purpose: types shared by the sampling controller and its bench
// Assumes: nothing
// Notes: offsets live in sampling_ctl_regs.svh
package sampling_ctl_pkg;
  // one retired instruction
  typedef struct packed {
    logic valid;
    logic fused;
    logic [31:0] ip;
  } retire_t;
  // one counted event with its memory information
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [7:0] umask;
    logic fused;
    logic [31:0] lin_addr;
    logic [5:0] data_src;
    logic [15:0] latency;
    logic [5:0] store_status;
  } event_t;
  // one sampling record handed to the store path
  typedef struct packed {
    logic valid;
    logic [31:0] slot;
    logic [1:0] counter;
    logic [31:0] ip;
    logic [31:0] lin_addr;
    logic [31:0] src_status;
    logic [31:0] latency;
  } record_t;
  typedef enum logic [1:0] {st_idle, st_skid, st_write} samp_state_t;
endpackage

// ### src/precise_event_sampling_ctl.sv
// Purpose: precise event sampling control with apb registers
// Assumes: pclk 25 MHz, events and retirements arrive on pclk
// Notes: counters 0..3 live here; 4..7 only report overflow
//
// The implementer's own choices: the address map and the APB interface to the registers.
`include "sampling_ctl_regs.svh"
module precise_event_sampling_ctl #(
  parameter int CW = 32 // general counter width
) (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire sampling_ctl_pkg::event_t ev, // counted event
  input wire sampling_ctl_pkg::retire_t ret, // retired instruction
  input wire logic [3:0] hi_ovf, // overflow pulses of counters 4-7
  output sampling_ctl_pkg::record_t rec // record write pulse
);
  import sampling_ctl_pkg::*;

  logic [3:0] sen_q; // sampling enable, counters 0..3
  logic [3:0] ll_q; // load latency enables
  logic store_cap_q; // store capture enable
  logic [7:0] ovf_q; // counter overflow status
  logic buf_full_q; // record buffer full flag
  logic [31:0] limit_q; // record slots available
  logic [31:0] count_q; // records written
  logic [31:0] evsel_q [4];
  logic [CW-1:0] cnt_q [4];
  logic [CW-1:0] reload_q [4];
  logic [3:0] armed_q;
  samp_state_t state_q;
  logic [1:0] skid_q; // retirements still to pass
  logic [1:0] ctr_q; // counter that fired
  event_t cap_q; // event captured at firing
  logic [31:0] ip_q; // sampled ip
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  record_t rec_q;

  // event table: is this code/umask sampleable on counter idx
  function automatic logic sampleable(input logic [7:0] code,
      input logic [7:0] um, input logic [1:0] idx);
    logic ok;
    ok = 1'b0;
    unique case (code)
      `EV_INSTR: ok = (um == 8'h01) && (idx == 2'd1);
      `EV_UOPS: ok = (um == 8'h01) || (um == 8'h02);
      `EV_BRANCH: ok = (um == 8'h01) || (um == 8'h02) || (um == 8'h04)
          || (um == 8'h08) || (um == 8'h20);
      `EV_MISPRED: ok = (um == 8'h01) || (um == 8'h02) || (um == 8'h04)
          || (um == 8'h10) || (um == 8'h20);
      `EV_MEMOP: ok = (um == 8'h11) || (um == 8'h12) || (um == 8'h21)
          || (um == 8'h41) || (um == 8'h42) || (um == 8'h81)
          || (um == 8'h82);
      `EV_LOADSRC: ok = (um == 8'h01) || (um == 8'h02) || (um == 8'h04)
          || (um == 8'h40);
      `EV_LLHIT: ok = (um == 8'h01) || (um == 8'h02) || (um == 8'h04)
          || (um == 8'h08);
      `EV_LOADLAT: ok = (um == `UM_LOADLAT);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // apb decode
  wire wr_en = psel && penable && pready_q && pwrite;
  wire [1:0] sub = paddr[3:2];
  wire hit_sen_lo = paddr == `OFS_SEN_LO;
  wire hit_sen_hi = paddr == `OFS_SEN_HI;
  wire hit_status = paddr == `OFS_STATUS;
  wire hit_limit = paddr == `OFS_REC_LIMIT;
  wire hit_count = paddr == `OFS_REC_COUNT;
  wire hit_evsel = paddr[7:4] == `OFS_EVSEL_BASE >> 4 && paddr[1:0] == 2'b00;
  wire hit_cnt = paddr[7:4] == `OFS_COUNT_BASE >> 4 && paddr[1:0] == 2'b00;
  wire hit_rld = paddr[7:4] == `OFS_RELOAD_BASE >> 4 && paddr[1:0] == 2'b00;
  wire mapped = hit_sen_lo || hit_sen_hi || hit_status || hit_limit
      || hit_count || hit_evsel || hit_cnt || hit_rld;
  wire [31:0] rd_mux =
      hit_sen_lo ? {28'h0, sen_q} :
      hit_sen_hi ? {store_cap_q, 27'h0, ll_q} :
      hit_status ? {23'h0, buf_full_q, ovf_q} :
      hit_limit ? limit_q :
      hit_count ? count_q :
      hit_evsel ? evsel_q[sub] :
      hit_cnt ? 32'(cnt_q[sub]) :
      hit_rld ? 32'(reload_q[sub]) : `RST_WORD;

  // apb answer: one wait state, data and error from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= `RST_WORD;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      prdata_q <= (psel && penable && !pready_q && !pwrite) ? rd_mux
          : `RST_WORD;
      pslverr_q <= psel && penable && !pready_q && !mapped;
    end
  end

  // per counter: matching, counting, overflow and arming
  logic [3:0] inc, wrap, fire, cnt_wr, rld_wr, evsel_wr;
  wire do_write = state_q == st_write;
  wire room = count_q < limit_q; // bounds check
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ctr
      wire [7:0] sel_code = evsel_q[i][7:0];
      wire [7:0] sel_um = evsel_q[i][15:8];
      assign inc[i] = ev.valid && evsel_q[i][`EVSEL_EN_BIT]
          && ev.code == sel_code && ev.umask == sel_um;
      assign wrap[i] = inc[i] && (cnt_q[i] == {CW{1'b1}});
      assign fire[i] = inc[i] && armed_q[i];
      assign cnt_wr[i] = wr_en && hit_cnt && sub == 2'(i);
      assign rld_wr[i] = wr_en && hit_rld && sub == 2'(i);
      assign evsel_wr[i] = wr_en && hit_evsel && sub == 2'(i);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q[i] <= '0;
          reload_q[i] <= '0;
          evsel_q[i] <= `RST_WORD;
          armed_q[i] <= 1'b0;
        end else begin
          if (evsel_wr[i]) evsel_q[i] <= pwdata;
          if (rld_wr[i]) reload_q[i] <= pwdata[CW-1:0];
          if (cnt_wr[i]) cnt_q[i] <= pwdata[CW-1:0];
          else if (do_write && armed_q[i] && room) cnt_q[i] <= reload_q[i];
          else if (inc[i]) cnt_q[i] <= cnt_q[i] + 1'b1;
          if (do_write) armed_q[i] <= 1'b0;
          else if (wrap[i] && sen_q[i]
              && sampleable(sel_code, sel_um, 2'(i))) armed_q[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // lowest firing counter wins; counters 4..7 never arm
  wire [1:0] fire_idx = fire[0] ? 2'd0 : fire[1] ? 2'd1 :
      fire[2] ? 2'd2 : 2'd3;
  wire is_store = store_cap_q && ctr_q == 2'd3;
  // every overflowed sampling counter clears, armed or not
  wire [3:0] ovf_clr = (do_write && room) ? (sen_q & ovf_q[3:0])
      : 4'h0;
  wire [7:0] ovf_set = {hi_ovf, wrap};
  wire [7:0] ovf_w1c = (wr_en && hit_status) ? pwdata[7:0] : 8'h00;
  wire [31:0] count_nx = count_q + 32'h1;

  // sampling sequencer: wait for the skid, then write or skip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
      skid_q <= 2'd0;
      ctr_q <= 2'd0;
      cap_q <= '0;
      ip_q <= `RST_WORD;
    end else begin
      unique case (state_q)
        st_idle: if (|fire) begin
          state_q <= st_skid;
          ctr_q <= fire_idx;
          cap_q <= ev;
          skid_q <= ev.fused ? `SKID_FUSED : `SKID_PLAIN;
        end
        st_skid: if (ret.valid) begin
          skid_q <= skid_q - 2'd1;
          if (skid_q == 2'd1) begin
            ip_q <= ret.ip;
            state_q <= st_write;
          end
        end
        st_write: state_q <= st_idle;
      endcase
    end
  end

  // record output and status registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_q <= '0;
      ovf_q <= 8'h00;
      buf_full_q <= 1'b0;
      count_q <= `RST_WORD;
      limit_q <= `RST_WORD;
      sen_q <= 4'h0;
      ll_q <= 4'h0;
      store_cap_q <= 1'b0;
    end else begin
      rec_q.valid <= do_write && room;
      if (do_write && room) begin
        rec_q.slot <= count_q;
        rec_q.counter <= ctr_q;
        rec_q.ip <= ip_q;
        rec_q.lin_addr <= cap_q.lin_addr;
        rec_q.src_status <= is_store ? {26'h0, cap_q.store_status}
            : ll_q[ctr_q] ? {26'h0, cap_q.data_src} : `RST_WORD;
        rec_q.latency <= is_store ? `RST_WORD
            : ll_q[ctr_q] ? {16'h0, cap_q.latency} : `RST_WORD;
      end
      // set wins over a software clear in the same cycle
      ovf_q <= ((ovf_q & ~ovf_w1c) & ~{4'h0, ovf_clr}) | ovf_set;
      if (do_write && room && count_nx >= limit_q) buf_full_q <= 1'b1;
      else if (wr_en && hit_status && pwdata[`STATUS_BUF_FULL_BIT])
        buf_full_q <= 1'b0;
      if (wr_en && hit_count) count_q <= pwdata;
      else if (do_write && room) count_q <= count_nx;
      if (wr_en && hit_limit) limit_q <= pwdata;
      if (wr_en && hit_sen_lo) sen_q <= pwdata[3:0];
      if (wr_en && hit_sen_hi) begin
        ll_q <= pwdata[3:0];
        store_cap_q <= pwdata[`SEN_STORE_BIT];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rec = rec_q;
endmodule // precise_event_sampling_ctl

// ### test/sampling_ctl_monitor.sv
// Purpose: port-level checks of the sampling controller
// Assumes: one apb wait state, record two cycles after last retirement
// Notes: bound to every instance of the controller
module sampling_ctl_monitor (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire sampling_ctl_pkg::event_t ev, // event
  input wire sampling_ctl_pkg::retire_t ret, // retirement
  input wire logic [3:0] hi_ovf, // upper overflows
  input wire sampling_ctl_pkg::record_t rec // record
);
  import sampling_ctl_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // setup then first access cycle
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  property p_ready;
    s_access |=> pready;
  endproperty
  property p_pulse;
    pready |=> !pready;
  endproperty
  property p_rdzero;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_after;
    rec.valid |-> $past(ret.valid, 2);
  endproperty
  property p_ip;
    rec.valid |-> rec.ip == $past(ret.ip, 2);
  endproperty
  property p_recpulse;
    rec.valid |=> !rec.valid;
  endproperty
  property p_hold;
    !rec.valid |-> $stable(rec.ip) && $stable(rec.lin_addr);
  endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  a_pulse: assert property (p_pulse) else $error("ready too long");
  a_rdzero: assert property (p_rdzero) else $error("stray read data");
  a_err: assert property (p_err) else $error("error without ready");
  a_after: assert property (p_after) else $error("record early");
  a_ip: assert property (p_ip) else $error("wrong sampled ip");
  a_recpulse: assert property (p_recpulse) else $error("long record");
  a_hold: assert property (p_hold) else $error("record moved");
endmodule // sampling_ctl_monitor
bind precise_event_sampling_ctl sampling_ctl_monitor mon_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ev(ev), .ret(ret), .hi_ovf(hi_ovf), .rec(rec));

// ### test/tb.sv
// Purpose: self-checking bench for the sampling controller
// Assumes: counters preset to all ones, so two events arm and fire
// Notes: notes queued by the drivers, popped by the watcher
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sampling_ctl_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  event_t ev = '0;
  retire_t ret = '0;
  logic [3:0] hi_ovf = 4'h0;
  record_t rec;
  int miscompares = 0, samples_checked = 0;
  integer seed = 32'h88FE10E1;
  logic [32:0] aq[$];
  logic [161:0] rq[$];
  int nslot = 0; // slot the next record should land in
  logic [15:0] tbl[27] = '{16'hC201, 16'hC202, 16'hC401, 16'hC402, 16'hC404,
    16'hC408, 16'hC420, 16'hC501, 16'hC502, 16'hC504, 16'hC510, 16'hC520,
    16'hD011, 16'hD012, 16'hD021, 16'hD041, 16'hD042, 16'hD081, 16'hD082,
    16'hD101, 16'hD102, 16'hD104, 16'hD140, 16'hD201, 16'hD202, 16'hD204,
    16'hD208};
  initial forever #20 pclk = ~pclk;
  precise_event_sampling_ctl dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ev(ev), .ret(ret), .hi_ovf(hi_ovf), .rec(rec));
  task chk(input logic [161:0] s, input logic [161:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watcher: oldest note for each bus answer and each record
  always @(posedge pclk) begin
    if (pready === 1'b1)
      chk({pslverr, pwrite ? 32'h0 : prdata}, aq.pop_front());
    if (rec.valid === 1'b1) chk({rec.slot, rec.counter, rec.ip, rec.lin_addr,
      rec.src_status, rec.latency}, rq.size() ? rq.pop_front() : '1);
  end
  // one apb transfer; e is {error, read data}
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    int n;
    n = 0;
    aq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // wrap event, firing event, skid retirements; m: 1 latency, 2 store
  task smp(input logic [1:0] c, input logic [15:0] cu, input logic f,
    input logic [1:0] m, input logic x);
    event_t e;
    logic [31:0] ip;
    e = {1'b1, cu, f, 32'($random(seed)), 28'($random(seed))};
    ip = 32'h0;
    ev <= {1'b1, cu, 1'b0, 60'h0};
    @(posedge pclk) ev <= e;
    for (int i = 0; i <= f; i++) begin
      @(posedge pclk) ev <= '0;
      ip = $random(seed);
      ret <= {1'b1, 1'b0, ip};
    end
    @(posedge pclk) ret <= '0;
    if (x) begin
      rq.push_back({32'(nslot), c, ip, e.lin_addr,
        m == 2 ? {26'h0, e.store_status}
        : m == 1 ? {26'h0, e.data_src} : 32'h0,
        m == 1 ? {16'h0, e.latency} : 32'h0});
      nslot++;
    end
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 'h50; i += 4)
      apb(1'b0, 8'(i), 32'h0, {i inside {'h14, 'h18, 'h1C}, 32'h0});
    apb(1'b1, 8'h1C, 32'hFFFF_FFFF, 33'h1_0000_0000);
    apb(1'b1, 8'h00, 32'hFF, 33'h0);
    apb(1'b0, 8'h00, 32'h0, 33'h0F);
    apb(1'b1, 8'h0C, 32'd100, 33'h0);
    for (int i = 0; i < 8; i++)
      apb(1'b1, 8'h30 + 8'(i * 4), 32'hFFFF_FFFF, 33'h0);
    $display("test registers done");
    apb(1'b1, 8'h24, 32'h0040_01C0, 33'h0);
    smp(2'd1, 16'hC001, 1'b0, 2'd0, 1'b1);
    apb(1'b1, 8'h04, 32'h2, 33'h0);
    smp(2'd1, 16'hC001, 1'b1, 2'd1, 1'b1);
    apb(1'b1, 8'h24, 32'h0, 33'h0);
    apb(1'b1, 8'h04, 32'h8000_0000, 33'h0);
    apb(1'b1, 8'h2C, 32'h0040_82D0, 33'h0);
    smp(2'd3, 16'hD082, 1'b0, 2'd2, 1'b1);
    apb(1'b1, 8'h2C, 32'h0040_10C4, 33'h0);
    smp(2'd3, 16'hC410, 1'b0, 2'd2, 1'b0);
    apb(1'b1, 8'h20, 32'h0040_01C0, 33'h0);
    smp(2'd0, 16'hC001, 1'b0, 2'd0, 1'b0);
    hi_ovf <= 4'hF;
    @(posedge pclk) hi_ovf <= 4'h0;
    apb(1'b0, 8'h08, 32'h0, 33'h0F9);
    apb(1'b1, 8'h08, 32'h9, 33'h0);
    $display("test counter limits done");
    foreach (tbl[i]) begin
      apb(1'b1, 8'h28, 32'h0, 33'h0);
      apb(1'b1, 8'h28, {16'h0040, tbl[i][7:0], tbl[i][15:8]}, 33'h0);
      smp(2'd2, tbl[i], 1'b0, 2'd0, 1'b1);
    end
    apb(1'b0, 8'h08, 32'h0, 33'h0F0);
    apb(1'b1, 8'h10, 32'd99, 33'h0);
    nslot = 99;
    smp(2'd2, 16'hD208, 1'b0, 2'd0, 1'b1);
    smp(2'd2, 16'hD208, 1'b0, 2'd0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 33'h1F4);
    apb(1'b0, 8'h10, 32'h0, 33'd100);
    $display("test events done");
    summarize();
  end
  initial begin
    #800000;
    miscompares++;
    summarize();
  end
endmodule // tb
